// file: design/mrs_reset_seq.sv
// Reset sequencer: reset sources, settle wait, vector fetch, reset values
`timescale 1ns/1ns
`include "mrs_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module mrs_reset_seq #(
  parameter int SETTLE_CYCLES = `MRS_SETTLE_CYC,
  parameter int RST_MIN_CYCLES = `MRS_RST_MIN_CYC,
  parameter int WDT_HOLD_CYCLES = `MRS_WDT_HOLD_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic reset_pin_n,
  input wire logic wdt_overflow,
  input wire logic stop_mode,
  input wire logic standby_mode,
  input wire logic [7:0] vec_byte,
  input wire logic vec_valid,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic core_rst_n,
  output logic pins_hiz,
  output logic main_osc_en,
  output logic sub_osc_en,
  output logic stop_hold,
  output logic ram_retain,
  output mrs_pkg::mrs_vec_req_type vec_req,
  output logic [15:0] pc,
  output logic pc_load,
  output logic init_load,
  output mrs_pkg::mrs_init_type init_vals
);
  import mrs_pkg::*;

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam int LW = $clog2(RST_MIN_CYCLES + 1);
  localparam int WW = $clog2(WDT_HOLD_CYCLES + 1);

  mrs_state_type state_r;
  mrs_state_type state_nxt;
  logic [2:0] pin_sync_r;
  logic pin_high_r;
  logic [CW-1:0] settle_cnt_r;
  logic [LW-1:0] low_cnt_r;
  logic [WW-1:0] wdt_hold_r;
  logic [1:0] ctrl_r;
  logic [2:0] cause_r;
  logic [7:0] vec_lo_r;
  logic [15:0] pc_r;
  logic wdt_hit;
  logic rst_req;
  logic rst_enter;
  logic bus_valid;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [2:0] cause_set;
  logic [2:0] cause_clr;

  function automatic logic [31:0] reg_read(input logic [7:0] off,
                                           input mrs_state_type st);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (off)
      `MRS_OFF_CTRL: d = {30'h0000_0000, ctrl_r};
      `MRS_OFF_STATUS: d = {26'h000_0000, main_osc_en, pins_hiz, core_rst_n, st};
      `MRS_OFF_CAUSE: d = {29'h0000_0000, cause_r};
      `MRS_OFF_VECTOR: d = {16'h0000, pc_r};
      `MRS_OFF_SETTLE: d = 32'(settle_cnt_r);
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : reg_read

  //////////////////////////////////////////////////////////////////////////////
  // Reset pin synchroniser: a level counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], reset_pin_n};
    end
  end

  // Starts low so the block comes up in reset until the pin is seen high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_high_r <= 1'b0;
    end else if (pin_sync_r[1] == pin_sync_r[2]) begin
      pin_high_r <= pin_sync_r[2];
    end
  end

  // Length of the low pulse; a release before the minimum is flagged
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_r <= '0;
    end else if (pin_high_r) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != LW'(RST_MIN_CYCLES)) begin
      low_cnt_r <= low_cnt_r + LW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset sources
  assign wdt_hit = (wdt_overflow && ctrl_r[`MRS_CTRL_WDT_EN]) || ctrl_r[`MRS_CTRL_SOFT];
  assign rst_req = !pin_high_r || wdt_hit || (wdt_hold_r != '0);
  assign rst_enter = rst_req && (state_r != ST_RESET);

  // Watchdog reset holds a few cycles, then lets go by itself
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_hold_r <= '0;
    end else if (wdt_hit) begin
      wdt_hold_r <= WW'(WDT_HOLD_CYCLES);
    end else if (wdt_hold_r != '0) begin
      wdt_hold_r <= wdt_hold_r - WW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET: if (!rst_req) state_nxt = ST_SETTLE;
      ST_SETTLE: if (settle_cnt_r == '0) state_nxt = ST_VEC_LO;
      ST_VEC_LO: if (vec_valid) state_nxt = ST_VEC_HI;
      ST_VEC_HI: if (vec_valid) state_nxt = ST_RUN;
      ST_RUN: state_nxt = ST_RUN;
      default: state_nxt = ST_RESET;
    endcase
    if (rst_req) begin
      state_nxt = ST_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settle counter; the wait runs on the main oscillator, which is restarted
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt_r <= CW'(SETTLE_CYCLES - 1);
    end else if (state_nxt == ST_SETTLE && state_r != ST_SETTLE) begin
      settle_cnt_r <= CW'(SETTLE_CYCLES - 1);
    end else if (state_r == ST_SETTLE && settle_cnt_r != '0) begin
      settle_cnt_r <= settle_cnt_r - CW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins, oscillators and core release
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_hiz <= 1'b1;
      main_osc_en <= 1'b0;
      sub_osc_en <= 1'b1;
      core_rst_n <= 1'b0;
    end else begin
      pins_hiz <= (state_nxt == ST_RESET) || (state_nxt == ST_SETTLE);
      main_osc_en <= (state_nxt != ST_RESET);
      sub_osc_en <= 1'b1;
      core_rst_n <= (state_nxt == ST_RUN);
    end
  end

  // STOP contents and standby RAM survive a reset that lands in those modes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_hold <= 1'b0;
      ram_retain <= 1'b0;
    end else if (rst_enter) begin
      stop_hold <= stop_mode;
      ram_retain <= standby_mode || stop_mode;
    end else if (state_nxt != ST_RESET) begin
      stop_hold <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Vector fetch and program counter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vec_req <= '0;
      vec_lo_r <= 8'h00;
      pc_r <= 16'h0000;
      pc_load <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      vec_req.req <= (state_nxt == ST_VEC_LO) || (state_nxt == ST_VEC_HI);
      vec_req.addr <= (state_nxt == ST_VEC_HI) ? `MRS_VEC_HI_ADDR : `MRS_VEC_LO_ADDR;
      if (state_r == ST_VEC_LO && vec_valid) begin
        vec_lo_r <= vec_byte;
      end
      if (state_r == ST_VEC_HI && vec_valid && !rst_req) begin
        pc_r <= {vec_byte, vec_lo_r};
        pc_load <= 1'b1;
      end
    end
  end

  // Before the first vector load the counter holds no meaning
  assign pc = pc_r;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values; undefined state (stack, RAM, compare, shift, result) is not driven
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_load <= 1'b1;
    end else begin
      init_load <= (state_nxt == ST_RESET);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_vals <= '0;
    end else begin
      init_vals.processor_status_word <= `MRS_PSW_RST;
      init_vals.port_latch <= `MRS_PORT_LATCH_RST;
      init_vals.port_direction <= `MRS_PORT_DIR_RST;
      init_vals.pullup_option <= `MRS_PULLUP_RST;
      init_vals.cpu_clock_control <= `MRS_CPU_CLK_RST;
      init_vals.osc_mode <= `MRS_OSC_MODE_RST;
      init_vals.expansion_ram_size <= `MRS_XRAM_SIZE_RST;
      init_vals.memory_expansion_mode <= `MRS_MEM_MODE_RST;
      init_vals.settle_time_select <= `MRS_SETTLE_SEL_RST;
      init_vals.timer_ctrl <= `MRS_TIMER_RST;
      init_vals.capture_compare_ctrl <= `MRS_CCC_RST;
      init_vals.serial_clock_select <= `MRS_SER_CLK_RST;
      init_vals.uart_tx_shift <= `MRS_UART_TX_RST;
      init_vals.serial_ctrl <= `MRS_SER_CTRL_RST;
      init_vals.converter_mode <= `MRS_CONV_MODE_RST;
      init_vals.converter_input <= `MRS_CONV_IN_RST;
      init_vals.patch_address_0 <= `MRS_PATCH_ADDR_RST;
      init_vals.patch_address_1 <= `MRS_PATCH_ADDR_RST;
      init_vals.patch_control <= `MRS_PATCH_CTRL_RST;
      init_vals.interrupt_request_flags <= `MRS_IRQ_REQ_RST;
      init_vals.interrupt_mask_flags <= `MRS_IRQ_MASK_RST;
      init_vals.interrupt_priority_flags <= `MRS_IRQ_PRIO_RST;
      init_vals.ext_int_mode <= `MRS_EXT_INT_RST;
      init_vals.sample_clock_select <= `MRS_SAMPLE_CLK_RST;
      init_vals.key_return_mode <= `MRS_KEY_RET_RST;
      init_vals.watch_timer_mode <= `MRS_MISC_RST;
      init_vals.watchdog_mode <= `MRS_MISC_RST;
      init_vals.dac_ctrl <= `MRS_MISC_RST;
      init_vals.rtp_ctrl <= `MRS_MISC_RST;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait, read data captured at the address phase
  assign bus_valid = hsel && htrans[1] && hready && (hsize == 3'h2);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= bus_valid && hwrite;
      if (bus_valid) begin
        wr_addr_r <= haddr[7:0];
      end
      if (bus_valid && !hwrite) begin
        hrdata <= (haddr[31:8] == 24'h00_0000) ? reg_read(haddr[7:0], state_r) : '0;
      end
    end
  end

  // Soft bit requests a watchdog-style reset and clears itself next cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `MRS_CTRL_RST;
    end else if (wr_pend_r && wr_addr_r == `MRS_OFF_CTRL) begin
      ctrl_r <= hwdata[1:0];
    end else begin
      ctrl_r[`MRS_CTRL_SOFT] <= 1'b0;
    end
  end

  // Cause flags: a new event in the clearing cycle wins over the clear
  always_comb begin
    cause_set = 3'h0;
    cause_set[`MRS_CAUSE_EXT] = !pin_high_r && (state_r != ST_RESET);
    cause_set[`MRS_CAUSE_WDT] = wdt_hit;
    cause_set[`MRS_CAUSE_SHORT] = (pin_sync_r[1] == pin_sync_r[2]) && pin_sync_r[2]
      && !pin_high_r && (low_cnt_r < LW'(RST_MIN_CYCLES));
    cause_clr = (wr_pend_r && wr_addr_r == `MRS_OFF_CAUSE) ? hwdata[2:0] : 3'h0;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_r <= 3'h0;
    end else begin
      cause_r <= (cause_r & ~cause_clr) | cause_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [CW:0] settle_seen_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_seen_r <= '0;
    end else if (state_r == ST_SETTLE) begin
      settle_seen_r <= settle_seen_r + (CW+1)'(1);
    end else begin
      settle_seen_r <= '0;
    end
  end

  pin_enters_reset_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !pin_high_r |=> state_r == ST_RESET && init_load)
    else $error("pin low did not enter reset");

  pins_float_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_r == ST_RESET || state_r == ST_SETTLE) |-> pins_hiz)
    else $error("pins driven during reset or settle");

  settle_length_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_r == ST_SETTLE && state_nxt == ST_VEC_LO) |-> settle_seen_r == (CW+1)'(SETTLE_CYCLES - 1))
    else $error("settle wait has the wrong length");

  wdt_self_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (wdt_overflow && ctrl_r[0] && pin_high_r) ##1 (pin_high_r && !wdt_overflow)[*6]
    |-> ##[0:2] state_r == ST_SETTLE)
    else $error("watchdog reset did not release");

  main_osc_stop_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(state_r == ST_RESET) |-> !main_osc_en && sub_osc_en)
    else $error("oscillators wrong in reset");

  stop_kept_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (rst_enter && stop_mode) |=> stop_hold && pins_hiz)
    else $error("stop state not held in reset");

  vector_order_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_r == ST_VEC_LO && vec_valid && !rst_req) |=> vec_req.addr == 16'h0001)
    else $error("vector high byte not requested");

  pc_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pc_load |-> core_rst_n && !pins_hiz && $past(state_r) == ST_VEC_HI)
    else $error("pc loaded outside vector fetch");

  psw_value_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(init_load) |-> init_vals.processor_status_word == 8'h02
      && init_vals.port_direction == 8'hFF)
    else $error("reset values wrong at release");

endmodule : mrs_reset_seq

// file: design/mrs_cfg.svh
// Offsets, reset values and timing counts of the reset sequencer
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH

// Timing: main oscillator period and sequencer clock period in ns
`define MRS_CLK_NS 50
`define MRS_MAIN_OSC_NS 50
`define MRS_SETTLE_PERIODS 131072
`define MRS_SETTLE_CYC ((`MRS_SETTLE_PERIODS * `MRS_MAIN_OSC_NS) / `MRS_CLK_NS)
`define MRS_RST_MIN_NS 10000
`define MRS_RST_MIN_CYC ((`MRS_RST_MIN_NS + `MRS_CLK_NS - 1) / `MRS_CLK_NS)
`define MRS_WDT_HOLD_CYC 4

// Reset vector bytes
`define MRS_VEC_LO_ADDR 16'h0000
`define MRS_VEC_HI_ADDR 16'h0001

// Register byte offsets
`define MRS_OFF_CTRL 8'h00
`define MRS_OFF_STATUS 8'h04
`define MRS_OFF_CAUSE 8'h08
`define MRS_OFF_VECTOR 8'h0C
`define MRS_OFF_SETTLE 8'h10

// Field positions
`define MRS_CTRL_WDT_EN 0
`define MRS_CTRL_SOFT 1
`define MRS_CAUSE_EXT 0
`define MRS_CAUSE_WDT 1
`define MRS_CAUSE_SHORT 2
`define MRS_CTRL_RST 2'h1

// Reset values loaded into CPU and peripheral state
`define MRS_PSW_RST 8'h02
`define MRS_PORT_LATCH_RST 8'h00
`define MRS_PORT_DIR_RST 8'hFF
`define MRS_PULLUP_RST 8'h00
`define MRS_CPU_CLK_RST 8'h04
`define MRS_OSC_MODE_RST 8'h00
`define MRS_XRAM_SIZE_RST 8'h0A
`define MRS_MEM_MODE_RST 8'h10
`define MRS_SETTLE_SEL_RST 8'h04
`define MRS_TIMER_RST 8'h00
`define MRS_CCC_RST 8'h04
`define MRS_SER_CLK_RST 8'h88
`define MRS_UART_TX_RST 8'hFF
`define MRS_SER_CTRL_RST 8'h00
`define MRS_CONV_MODE_RST 8'h01
`define MRS_CONV_IN_RST 8'h00
`define MRS_PATCH_ADDR_RST 16'h0000
`define MRS_PATCH_CTRL_RST 8'h00
`define MRS_IRQ_REQ_RST 8'h00
`define MRS_IRQ_MASK_RST 8'hFF
`define MRS_IRQ_PRIO_RST 8'hFF
`define MRS_EXT_INT_RST 8'h00
`define MRS_SAMPLE_CLK_RST 8'h00
`define MRS_KEY_RET_RST 8'h02
`define MRS_MISC_RST 8'h00

`endif

// file: design/mrs_pkg.sv
// Types shared by the reset sequencer
package mrs_pkg;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_SETTLE,
    ST_VEC_LO,
    ST_VEC_HI,
    ST_RUN
  } mrs_state_type;

  // Values handed to CPU and peripherals while init_load is high
  typedef struct packed {
    logic [7:0] processor_status_word;
    logic [7:0] port_latch;
    logic [7:0] port_direction;
    logic [7:0] pullup_option;
    logic [7:0] cpu_clock_control;
    logic [7:0] osc_mode;
    logic [7:0] expansion_ram_size;
    logic [7:0] memory_expansion_mode;
    logic [7:0] settle_time_select;
    logic [7:0] timer_ctrl;
    logic [7:0] capture_compare_ctrl;
    logic [7:0] serial_clock_select;
    logic [7:0] uart_tx_shift;
    logic [7:0] serial_ctrl;
    logic [7:0] converter_mode;
    logic [7:0] converter_input;
    logic [15:0] patch_address_0;
    logic [15:0] patch_address_1;
    logic [7:0] patch_control;
    logic [7:0] interrupt_request_flags;
    logic [7:0] interrupt_mask_flags;
    logic [7:0] interrupt_priority_flags;
    logic [7:0] ext_int_mode;
    logic [7:0] sample_clock_select;
    logic [7:0] key_return_mode;
    logic [7:0] watch_timer_mode;
    logic [7:0] watchdog_mode;
    logic [7:0] dac_ctrl;
    logic [7:0] rtp_ctrl;
  } mrs_init_type;

  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } mrs_vec_req_type;

endpackage : mrs_pkg

// file: tb/mrs_pin_driver.sv
// Model of the outside circuit that drives the active-low reset pin
`timescale 1ns/1ns
module mrs_pin_driver #(
  parameter int LOW_CYC = 200
) (
  input wire logic sys_clk,
  input wire logic req,
  input wire logic short_req,
  input wire logic slow,
  output logic reset_pin_n,
  output logic busy
);
  int cnt;

  // Power-on: the circuit holds the pin low from time zero
  initial begin
    reset_pin_n = 1'h0;
    busy = 1'h1;
    cnt = LOW_CYC;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Full width unless the bench asks for a too-short pulse on purpose
  always @(posedge sys_clk) begin
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        reset_pin_n <= 1'h1;
        busy <= 1'h0;
      end
    end else if (req) begin
      reset_pin_n <= 1'h0;
      busy <= 1'h1;
      cnt <= short_req ? 4 : (slow ? LOW_CYC + 100 : LOW_CYC);
    end
  end
endmodule : mrs_pin_driver

// file: tb/mrs_reset_seq_tb.sv
// Self-checking bench of the reset sequencer
`timescale 1ns/1ns
module mrs_reset_seq_tb;
  import mrs_pkg::*;
  localparam int SETTLE = 16;
  logic sys_clk = 1'h0;
  logic arst_n, wdt_overflow, stop_mode, standby_mode, vec_valid;
  logic [7:0] vec_byte;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic core_rst_n, pins_hiz, main_osc_en, sub_osc_en, stop_hold, ram_retain;
  logic pc_load, init_load, reset_pin_n, pin_req, pin_short, pin_slow, pin_busy;
  logic [15:0] pc;
  mrs_vec_req_type vec_req;
  mrs_init_type init_vals, exp_init;
  int n_errors = 0;
  int cmp_count = 0;

  always #25 sys_clk = ~sys_clk;

  mrs_pin_driver i_pin (.sys_clk(sys_clk), .req(pin_req), .short_req(pin_short),
    .slow(pin_slow), .reset_pin_n(reset_pin_n), .busy(pin_busy));

  mrs_reset_seq #(.SETTLE_CYCLES(SETTLE), .RST_MIN_CYCLES(8), .WDT_HOLD_CYCLES(4)) i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .reset_pin_n(reset_pin_n),
    .wdt_overflow(wdt_overflow), .stop_mode(stop_mode), .standby_mode(standby_mode),
    .vec_byte(vec_byte), .vec_valid(vec_valid), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_rst_n(core_rst_n),
    .pins_hiz(pins_hiz), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
    .stop_hold(stop_hold), .ram_retain(ram_retain), .vec_req(vec_req), .pc(pc),
    .pc_load(pc_load), .init_load(init_load), .init_vals(init_vals));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Single word transfer; waits on hready rather than assuming zero wait states
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    r = hrdata;
    check(hresp, 1'h0);
  endtask : ahb

  task automatic pin_start(input logic s, input logic sl);
    @(posedge sys_clk);
    pin_req <= 1'h1;
    pin_short <= s;
    pin_slow <= sl;
    @(posedge sys_clk);
    pin_req <= 1'h0;
  endtask : pin_start

  task automatic wait_pin;
    int n;
    n = 0;
    do @(posedge sys_clk); while (pin_busy !== 1'h0 && n++ < 1000);
    check(pin_busy, 1'h0);
  endtask : wait_pin

  // Settle wait, two vector byte reads, then core release
  task automatic boot(input logic [7:0] lo, input logic [7:0] hi);
    int n;
    logic held;
    n = 0;
    held = 1'h1;
    while (vec_req.req !== 1'h1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
      if (vec_req.req !== 1'h1 && (pins_hiz !== 1'h1 || core_rst_n !== 1'h0)) held = 1'h0;
    end
    check(n >= SETTLE && n <= SETTLE + 12, 1'h1);
    check(held, 1'h1);
    check(vec_req.addr, 16'h0000);
    vec_byte <= lo;
    vec_valid <= 1'h1;
    @(posedge sys_clk);
    vec_valid <= 1'h0;
    n = 0;
    do @(posedge sys_clk); while (vec_req.addr !== 16'h0001 && n++ < 50);
    check({vec_req.req, vec_req.addr}, 17'h1_0001);
    vec_byte <= hi;
    vec_valid <= 1'h1;
    @(posedge sys_clk);
    vec_valid <= 1'h0;
    @(posedge sys_clk);
    check(pc_load, 1'h1);
    repeat (3) @(posedge sys_clk);
    check(pc, {hi, lo});
    check({core_rst_n, pins_hiz, main_osc_en}, 3'h5);
  endtask : boot

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power_on;
    repeat (5) @(posedge sys_clk);
    check({core_rst_n, pins_hiz, main_osc_en, sub_osc_en, init_load}, 5'h0B);
    check(init_vals, exp_init);
    wait_pin();
    boot(8'h34, 8'h12);
  endtask : t_power_on

  task automatic t_stop;
    stop_mode <= 1'h1;
    pin_start(1'h0, 1'h1);
    repeat (10) @(posedge sys_clk);
    check({stop_hold, ram_retain, pins_hiz, sub_osc_en}, 4'hF);
    wait_pin();
    stop_mode <= 1'h0;
    boot(8'hA5, 8'h0F);
  endtask : t_stop

  task automatic t_watchdog;
    logic [31:0] r;
    ahb(1'h0, 32'h0000_0000, 32'h0000_0000, r);
    check(r[0], 1'h1);
    wdt_overflow <= 1'h1;
    @(posedge sys_clk);
    wdt_overflow <= 1'h0;
    repeat (3) @(posedge sys_clk);
    check({core_rst_n, pins_hiz, main_osc_en, init_load}, 4'h5);
    check(init_vals, exp_init);
    boot(8'h5A, 8'h3C);
    check(ram_retain, 1'h0);
    ahb(1'h0, 32'h0000_0008, 32'h0000_0000, r);
    check(r[1], 1'h1);
    ahb(1'h1, 32'h0000_0008, 32'h0000_0007, r);
    ahb(1'h0, 32'h0000_0008, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
  endtask : t_watchdog

  // Too-short pin pulse still resets; standby keeps RAM contents
  task automatic t_short_bus;
    logic [31:0] r;
    standby_mode <= 1'h1;
    pin_start(1'h1, 1'h0);
    wait_pin();
    standby_mode <= 1'h0;
    boot(8'hFF, 8'h80);
    check(ram_retain, 1'h1);
    ahb(1'h0, 32'h0000_0008, 32'h0000_0000, r);
    check(r[2:0], 3'h5);
    ahb(1'h0, 32'h0000_0004, 32'h0000_0000, r);
    check(r[5:0], 6'h2C);
    ahb(1'h0, 32'h0000_000C, 32'h0000_0000, r);
    check(r[15:0], 16'h80FF);
    ahb(1'h0, 32'h0000_0020, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
  endtask : t_short_bus

  // Disabled watchdog source is ignored; a software request takes the watchdog path
  task automatic t_soft;
    logic [31:0] r;
    ahb(1'h1, 32'h0000_0000, 32'h0000_0000, r);
    wdt_overflow <= 1'h1;
    @(posedge sys_clk);
    wdt_overflow <= 1'h0;
    repeat (3) @(posedge sys_clk);
    check({core_rst_n, pins_hiz}, 2'h2);
    ahb(1'h1, 32'h0000_0000, 32'h0000_0003, r);
    repeat (2) @(posedge sys_clk);
    check({core_rst_n, pins_hiz, init_load}, 3'h3);
    boot(8'h11, 8'h22);
    ahb(1'h0, 32'h0000_0000, 32'h0000_0000, r);
    check(r[1:0], 2'h1);
    ahb(1'h0, 32'h0000_0008, 32'h0000_0000, r);
    check(r[2:0], 3'h7);
    ahb(1'h0, 32'h0000_0010, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
  endtask : t_soft

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    exp_init = {8'h02, 8'h00, 8'hFF, 8'h00, 8'h04, 8'h00, 8'h0A, 8'h10, 8'h04, 8'h00,
      8'h04, 8'h88, 8'hFF, 8'h00, 8'h01, 8'h00, 16'h0000, 16'h0000, 8'h00, 8'h00,
      8'hFF, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    arst_n = 1'h0;
    wdt_overflow = 1'h0;
    stop_mode = 1'h0;
    standby_mode = 1'h0;
    vec_byte = 8'h00;
    vec_valid = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    pin_req = 1'h0;
    pin_short = 1'h0;
    pin_slow = 1'h0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'h1;
    t_power_on();
    t_stop();
    t_watchdog();
    t_short_bus();
    t_soft();
    report_and_stop();
  end

  // Whole run needs about 750 cycles
  initial begin
    #(6000 * 50);
    n_errors++;
    report_and_stop();
  end
endmodule : mrs_reset_seq_tb
